// ---- lnt_pkg.sv ----
package lnt_pkg;

    // Register byte offsets on the AHB-Lite bus.
    localparam logic [7:0] LNT_CTRL_OFS   = 8'h00;
    localparam logic [7:0] LNT_STAT_OFS   = 8'h04;
    localparam logic [7:0] LNT_IRQ_OFS    = 8'h08;
    localparam logic [7:0] LNT_MASK_OFS   = 8'h0C;

    // Control register fields.
    localparam int LNT_CTRL_MODE_LSB  = 0;   // Two bits: transceiver mode request.
    localparam int LNT_CTRL_RATE_LSB  = 2;   // Two bits: baud rate select.
    localparam int LNT_CTRL_WUEN_BIT  = 4;   // Wake-up detection enable.
    localparam int LNT_CTRL_NORM_BIT  = 5;   // Device is in Normal mode.
    localparam int LNT_CTRL_LPON_BIT  = 6;   // Low power with regulator on.
    localparam logic [6:0] LNT_CTRL_RESET = 7'h00;

    // Status register fields.
    localparam int LNT_STAT_MODE_LSB  = 0;   // Two bits: active mode.
    localparam int LNT_STAT_DOM_BIT   = 2;   // Permanent dominant lock active.
    localparam int LNT_STAT_UV_BIT    = 3;
    localparam int LNT_STAT_OT_BIT    = 4;
    localparam int LNT_STAT_BUS_BIT   = 5;   // Synchronised bus level.
    localparam int LNT_STAT_DRV_BIT   = 6;   // Driver currently active.

    // Sticky event bits, shared by interrupt and mask registers.
    localparam int LNT_EV_DOM   = 0;
    localparam int LNT_EV_WAKE  = 1;
    localparam int LNT_EV_UV    = 2;
    localparam int LNT_EV_OT    = 3;
    localparam int LNT_EV_W     = 4;

    // Transceiver modes.
    typedef enum logic [1:0] {
        LNT_MODE_DIS   = 2'b00,
        LNT_MODE_TXRX  = 2'b01,
        LNT_MODE_SLEEP = 2'b10
    } lnt_mode_e;

    // Baud rate codes.
    localparam logic [1:0] LNT_RATE_20K = 2'b00;
    localparam logic [1:0] LNT_RATE_10K = 2'b01;
    localparam logic [1:0] LNT_RATE_FAST = 2'b10;

    // Timing.
    localparam int LNT_CLK_MHZ      = 100;
    localparam int LNT_WAKE_US      = 70;
    localparam int LNT_WAKE_CYC     = LNT_WAKE_US * LNT_CLK_MHZ;
    localparam int LNT_TXDOM_US     = 300;
    localparam int LNT_TXDOM_CYC    = LNT_TXDOM_US * LNT_CLK_MHZ;
    localparam int LNT_CNT_W        = 16;

endpackage

// ---- lnt_top.sv ----
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// - Three transmit speeds, 20k, 10k and fast, chosen by a configuration write.
// - Supply undervoltage blocks transmit path and holds the bus recessive.
// - Overtemperature disables driver and receiver; both return when it clears.
// - Transceiver stays inactive unless the device is in Normal mode.
// - In transmit-receive mode bus follows transmit input: low drives, high releases.
// - Transmit low beyond the timeout forces recessive and sets a dominant flag.
// - Recessive lock holds until transmit input is no longer low.
// - Receive output high for recessive bus, low for dominant bus.
// - Two operational modes exist: transmit-receive and disabled.
// - Transmit-receive command accepted only while transmit input is high.
// - Sleep entered by command; transmit path off, bus watched for wake-up.
// - Sleep selects weak pull-up; otherwise the normal pull-up is connected.
// - Wake-up is falling edge, dominant over 70 us, then rising edge.
// - Wake-up reported; interrupt with regulator on, regulator restart when off; the wake-up interrupt is raised with the regulator off as well.
// - A software enable gates wake-up detection.
module lnt_top #(
    parameter int TXDOM_CYC = lnt_pkg::LNT_TXDOM_CYC,
    parameter int WAKE_CYC  = lnt_pkg::LNT_WAKE_CYC
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hsel,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        txd_in,
    output logic             rxd_out,
    input  wire logic        bus_in,
    output logic             bus_drive_low,
    output logic             weak_pullup_en,
    output logic             normal_pullup_en,
    input  wire logic        transceiver_supply_uv,
    input  wire logic        overtemp,
    output logic [1:0]       slew_rate_sel,
    output logic             wake_report,
    output logic             regulator_restart
);
    import lnt_pkg::*;

    logic [1:0]  txd_sync_reg;
    logic [1:0]  bus_sync_reg;
    logic [1:0]  uv_sync_reg;
    logic [1:0]  ot_sync_reg;
    logic [6:0]  ctrl_reg;
    logic [LNT_EV_W-1:0] ev_reg;
    logic [LNT_EV_W-1:0] mask_reg;
    lnt_mode_e   mode_reg;
    logic        dom_lock_reg;
    logic [LNT_CNT_W-1:0] dom_cnt_reg;
    logic [LNT_CNT_W-1:0] wake_cnt_reg;
    logic        wake_armed_reg;
    logic        bus_prev_reg;
    logic        dph_valid_reg;
    logic        dph_write_reg;
    logic [7:0]  dph_addr_reg;
    logic        wake_pulse;
    logic        txd_s;
    logic        bus_s;
    logic        uv_s;
    logic        ot_s;
    logic        drv_active;
    logic [LNT_EV_W-1:0] ev_set;
    logic [LNT_EV_W-1:0] ev_clr;
    logic        wr_ctrl;
    logic [1:0]  req_mode;

    // True for a register offset this slave maps.
    function automatic logic lnt_mapped(input logic [7:0] a);
        lnt_mapped = (a == LNT_CTRL_OFS) || (a == LNT_STAT_OFS) ||
                     (a == LNT_IRQ_OFS) || (a == LNT_MASK_OFS);
    endfunction

    // Only the second stage of each synchroniser is read by logic.
    assign txd_s = txd_sync_reg[1];
    assign bus_s = bus_sync_reg[1];
    assign uv_s  = uv_sync_reg[1];
    assign ot_s  = ot_sync_reg[1];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txd_sync_reg <= 2'h3;
            bus_sync_reg <= 2'h3;
            uv_sync_reg  <= 2'h0;
            ot_sync_reg  <= 2'h0;
        end else begin
            txd_sync_reg <= {txd_sync_reg[0], txd_in};
            bus_sync_reg <= {bus_sync_reg[0], bus_in};
            uv_sync_reg  <= {uv_sync_reg[0], transceiver_supply_uv};
            ot_sync_reg  <= {ot_sync_reg[0], overtemp};
        end
    end

    // AHB-Lite address phase capture; the slave never inserts wait states.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dph_valid_reg <= 1'b0;
            dph_write_reg <= 1'b0;
            dph_addr_reg  <= 8'h00;
        end else if (hready) begin
            dph_valid_reg <= hsel && htrans[1];
            dph_write_reg <= hwrite;
            dph_addr_reg  <= haddr[7:0];
        end
    end

    assign wr_ctrl  = dph_valid_reg && dph_write_reg && (dph_addr_reg == LNT_CTRL_OFS);
    assign req_mode = hwdata[LNT_CTRL_MODE_LSB +: 2];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg <= LNT_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= hwdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_reg <= '0;
        end else if (dph_valid_reg && dph_write_reg && (dph_addr_reg == LNT_MASK_OFS)) begin
            mask_reg <= hwdata[LNT_EV_W-1:0];
        end
    end

    // Mode state. A mode write is taken from the same data phase as the control word.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_reg <= LNT_MODE_DIS;
        end else if (wr_ctrl) begin
            case (req_mode)
                LNT_MODE_TXRX: begin
                    if (txd_s) begin
                        mode_reg <= LNT_MODE_TXRX;
                    end
                end
                LNT_MODE_SLEEP: mode_reg <= LNT_MODE_SLEEP;
                LNT_MODE_DIS: mode_reg <= LNT_MODE_DIS;
                default: mode_reg <= mode_reg;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dom_cnt_reg  <= '0;
            dom_lock_reg <= 1'b0;
        end else if (txd_s) begin
            dom_cnt_reg  <= '0;
            dom_lock_reg <= 1'b0;
        end else if (dom_cnt_reg >= LNT_CNT_W'(TXDOM_CYC - 1)) begin
            dom_lock_reg <= 1'b1;
        end else begin
            dom_cnt_reg <= dom_cnt_reg + 1'b1;
        end
    end

    // Driver may act only in Normal, transmit-receive, with no fault and no lock.
    // inactive outside Normal
    assign drv_active = ctrl_reg[LNT_CTRL_NORM_BIT] && (mode_reg == LNT_MODE_TXRX) &&
                        !uv_s && !ot_s && !dom_lock_reg;

    // Bus-facing and receive outputs, all registered.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_drive_low    <= 1'b0;
            rxd_out          <= 1'b1;
            weak_pullup_en   <= 1'b0;
            normal_pullup_en <= 1'b1;
            slew_rate_sel    <= LNT_RATE_20K;
        end else begin
            bus_drive_low <= drv_active && !txd_s;
            // rxd mirrors bus; receiver off when hot or not in Normal.
            rxd_out <= (ot_s || !ctrl_reg[LNT_CTRL_NORM_BIT]) ? 1'b1 : bus_s;
            weak_pullup_en   <= (mode_reg == LNT_MODE_SLEEP);
            normal_pullup_en <= (mode_reg != LNT_MODE_SLEEP);
            slew_rate_sel <= ctrl_reg[LNT_CTRL_RATE_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_prev_reg   <= 1'b1;
            wake_cnt_reg   <= '0;
            wake_armed_reg <= 1'b0;
        end else begin
            bus_prev_reg <= bus_s;
            if (mode_reg != LNT_MODE_SLEEP || !ctrl_reg[LNT_CTRL_WUEN_BIT]) begin
                wake_cnt_reg   <= '0;
                wake_armed_reg <= 1'b0;
            end else if (bus_prev_reg && !bus_s) begin
                wake_cnt_reg   <= '0;
                wake_armed_reg <= 1'b1;
            end else if (!bus_s && wake_armed_reg &&
                         wake_cnt_reg <= LNT_CNT_W'(WAKE_CYC)) begin
                wake_cnt_reg <= wake_cnt_reg + 1'b1;
            end else if (bus_s) begin
                wake_armed_reg <= 1'b0;
            end
        end
    end

    // Dominant must exceed the limit, so the count has to pass it before release.
    assign wake_pulse = (mode_reg == LNT_MODE_SLEEP) && ctrl_reg[LNT_CTRL_WUEN_BIT] &&
                        wake_armed_reg && !bus_prev_reg && bus_s &&
                        (wake_cnt_reg > LNT_CNT_W'(WAKE_CYC));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wake_report       <= 1'b0;
            regulator_restart <= 1'b0;
        end else begin
            wake_report       <= wake_pulse;
            regulator_restart <= wake_pulse && !ctrl_reg[LNT_CTRL_LPON_BIT];
        end
    end

    // Sticky events; a set in the clearing cycle wins.
    assign ev_set[LNT_EV_DOM]  = !txd_s && (dom_cnt_reg >= LNT_CNT_W'(TXDOM_CYC - 1)) &&
                                 !dom_lock_reg;
    assign ev_set[LNT_EV_WAKE] = wake_pulse;
    assign ev_set[LNT_EV_UV]   = uv_s;
    assign ev_set[LNT_EV_OT]   = ot_s;
    assign ev_clr = (dph_valid_reg && dph_write_reg && dph_addr_reg == LNT_IRQ_OFS) ?
                    hwdata[LNT_EV_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ev_reg <= '0;
        end else begin
            ev_reg <= (ev_reg & ~ev_clr) | ev_set;
        end
    end

    // interrupt for any pending event whose mask bit is set, wake-up included.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev_reg & mask_reg);
        end
    end

    // Read data: returned in the data phase from the captured address.
    always_comb begin
        hrdata = 32'h0000_0000;
        if (dph_valid_reg && !dph_write_reg) begin
            case (dph_addr_reg)
                LNT_CTRL_OFS: hrdata[6:0] = ctrl_reg;
                LNT_STAT_OFS: begin
                    hrdata[LNT_STAT_MODE_LSB +: 2] = mode_reg;
                    hrdata[LNT_STAT_DOM_BIT] = dom_lock_reg;
                    hrdata[LNT_STAT_UV_BIT]  = uv_s;
                    hrdata[LNT_STAT_OT_BIT]  = ot_s;
                    hrdata[LNT_STAT_BUS_BIT] = bus_s;
                    hrdata[LNT_STAT_DRV_BIT] = drv_active;
                end
                LNT_IRQ_OFS:  hrdata[LNT_EV_W-1:0] = ev_reg;
                LNT_MASK_OFS: hrdata[LNT_EV_W-1:0] = mask_reg;
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states, always OKAY; unmapped reads return zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= !lnt_mapped(8'h00) && 1'b0;
        end
    end

endmodule

// ---- lnt_lin_node.sv ----
`timescale 1ns/100ps
// Far side of the link: the controller's transmit pin and the other nodes on the wire.
module lnt_lin_node (
    input  wire logic clk,
    input  wire logic bus_drive_low,
    output logic      txd_in,
    output logic      bus_in
);
    logic remote_dom;
    // The pull-up makes a released wire recessive high, so no stale value can linger.
    assign bus_in = !(bus_drive_low || remote_dom);
    initial begin
        txd_in = 1'b1;
        remote_dom = 1'b0;
    end
    task automatic set_txd(input logic lvl);
        txd_in <= lvl;
    endtask
    // Another node pulls the wire dominant while lvl is high.
    task automatic set_remote(input logic lvl);
        remote_dom <= lvl;
    endtask
endmodule

// ---- lnt_top_asserts.sv ----
`timescale 1ns/100ps
// Watches the link pins for fault blocking, lock timing and wake-up qualification.
module lnt_top_asserts #(
    parameter int TXDOM_CYC = 50,
    parameter int WAKE_CYC  = 20
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       txd_in,
    input wire logic       rxd_out,
    input wire logic       bus_in,
    input wire logic       bus_drive_low,
    input wire logic       weak_pullup_en,
    input wire logic       normal_pullup_en,
    input wire logic       transceiver_supply_uv,
    input wire logic       overtemp,
    input wire logic [1:0] slew_rate_sel,
    input wire logic       wake_report,
    input wire logic       regulator_restart
);
    int drive_cnt;
    int txd_low_cnt;
    int low_run;
    int last_run;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Run lengths; the last bus-low run is kept since wake-up fires only after it ends.
    always_ff @(posedge clk) begin
        drive_cnt <= (sys_rst || !bus_drive_low) ? 0 : drive_cnt + 1;
        txd_low_cnt <= (sys_rst || txd_in) ? 0 : txd_low_cnt + 1;
        low_run <= (sys_rst || bus_in) ? 0 : low_run + 1;
        if (sys_rst) begin
            last_run <= 0;
        end else if (bus_in && low_run != 0) begin
            last_run <= low_run;
        end
    end
    sequence uv_held;
        transceiver_supply_uv [*5];
    endsequence
    sequence hot_held;
        overtemp [*5];
    endsequence
    uv_block_a: assert property (uv_held |-> !bus_drive_low)
        else $error("driver active during supply undervoltage");
    hot_off_a: assert property (hot_held |-> !bus_drive_low && rxd_out)
        else $error("transceiver active during overtemperature");
    dom_limit_a: assert property (drive_cnt <= TXDOM_CYC + 4)
        else $error("driver held dominant past the timeout");
    lock_hold_a: assert property ($rose(bus_drive_low) |-> txd_low_cnt < TXDOM_CYC)
        else $error("driver resumed while transmit input stayed low");
    rxd_mirror_a: assert property ($fell(rxd_out) |-> !$past(bus_in, 3) || !$past(bus_in, 2))
        else $error("receive output fell without a dominant bus");
    sleep_quiet_a: assert property (weak_pullup_en |-> !bus_drive_low)
        else $error("driver active in sleep");
    pullup_pair_a: assert property (normal_pullup_en == !weak_pullup_en)
        else $error("pull-up selection inconsistent");
    rate_code_a: assert property (slew_rate_sel != 2'b11)
        else $error("undefined rate code on output");
    wake_len_a: assert property ($rose(wake_report) |-> last_run >= WAKE_CYC)
        else $error("wake-up reported after a short dominant pulse");
    restart_len_a: assert property ($rose(regulator_restart) |-> last_run >= WAKE_CYC)
        else $error("regulator restart without a valid wake-up");
endmodule

bind lnt_top lnt_top_asserts #(.TXDOM_CYC(TXDOM_CYC), .WAKE_CYC(WAKE_CYC)) u_lnt_chk (
    .clk(clk), .sys_rst(sys_rst), .txd_in(txd_in), .rxd_out(rxd_out), .bus_in(bus_in),
    .bus_drive_low(bus_drive_low), .weak_pullup_en(weak_pullup_en),
    .normal_pullup_en(normal_pullup_en), .transceiver_supply_uv(transceiver_supply_uv),
    .overtemp(overtemp), .slew_rate_sel(slew_rate_sel), .wake_report(wake_report),
    .regulator_restart(regulator_restart)
);

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
    import lnt_pkg::*;
    localparam int TXDOM = 50;
    localparam int WAKE  = 20;
    logic        clk, sys_rst, hwrite, hreadyout, hresp, irq, txd_in, rxd_out, bus_in;
    logic        bus_drive_low, weak_pu, normal_pu, uv, ot, wake_report, reg_restart;
    logic [1:0]  htrans, slew_rate_sel;
    logic        hsel;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  rates [3] = '{LNT_RATE_20K, LNT_RATE_10K, LNT_RATE_FAST};
    int          n_errors, tests_run, n_wake, n_restart;
    lnt_top #(.TXDOM_CYC(TXDOM), .WAKE_CYC(WAKE)) dut (
        .clk(clk), .sys_rst(sys_rst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .txd_in(txd_in), .rxd_out(rxd_out),
        .bus_in(bus_in), .bus_drive_low(bus_drive_low), .weak_pullup_en(weak_pu),
        .normal_pullup_en(normal_pu), .transceiver_supply_uv(uv), .overtemp(ot),
        .slew_rate_sel(slew_rate_sel), .wake_report(wake_report),
        .regulator_restart(reg_restart));
    lnt_lin_node node (.clk(clk), .bus_drive_low(bus_drive_low), .txd_in(txd_in),
        .bus_in(bus_in));
    initial clk = 1'b0;
    always #5 clk = ~clk;
    // Pulses last one cycle, so they are counted here rather than polled.
    always @(posedge clk) begin
        n_wake <= n_wake + (wake_report === 1'b1 ? 1 : 0);
        n_restart <= n_restart + (reg_restart === 1'b1 ? 1 : 0);
    end
    task automatic end_sim();
        if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single AHB-Lite transfer; the wait for hready is bounded.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n;
        n = 0;
        haddr <= {24'h000000, a};
        hsel <= 1'b1;
        hsize <= 3'b010;
        htrans <= 2'b10;
        hwrite <= w;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 40) begin
            n_errors++;
            end_sim();
        end
    endtask
    function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [1:0] r,
                                         input logic wu, input logic lp);
        ctrl = {25'h0000000, lp, 1'b1, wu, r, m};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Another node holds the wire dominant for n cycles, then the line settles.
    task automatic pulse(input int n);
        node.set_remote(1'b1);
        cyc(n);
        node.set_remote(1'b0);
        cyc(10);
    endtask
    initial begin
        {haddr, hwdata, htrans, hwrite, uv, ot, hsel, hsize} = '0;
        {n_errors, tests_run, n_wake, n_restart} = '0;
        sys_rst = 1'b1;
        cyc(16);
        sys_rst <= 1'b0;
        cyc(2);
        check("reset pull-up", {weak_pu, normal_pu}, 32'h1);
        xfer(8'h10, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        xfer(LNT_CTRL_OFS, 1'b1, 32'h00000001);
        node.set_txd(1'b0);
        cyc(10);
        check("drive outside normal", {rxd_out, bus_drive_low}, 32'h2);
        node.set_txd(1'b1);
        cyc(4);
        for (int i = 0; i < 3; i++) begin
            xfer(LNT_CTRL_OFS, 1'b1, ctrl(LNT_MODE_TXRX, rates[i], 1'b0, 1'b0));
            xfer(LNT_CTRL_OFS, 1'b0, 32'h0);
            check("ctrl", rd, ctrl(LNT_MODE_TXRX, rates[i], 1'b0, 1'b0));
            check("rate", {30'h0, slew_rate_sel}, {30'h0, rates[i]});
        end
        xfer(LNT_STAT_OFS, 1'b0, 32'h0);
        check("txrx mode", {30'h0, rd[1:0]}, {30'h0, LNT_MODE_TXRX});
        node.set_txd(1'b0);
        cyc(8);
        check("dominant tx", {rxd_out, bus_drive_low}, 32'h1);
        node.set_txd(1'b1);
        cyc(8);
        check("recessive tx", {rxd_out, bus_drive_low}, 32'h2);
        node.set_remote(1'b1);
        cyc(8);
        check("rx dominant", {31'h0, rxd_out}, 32'h0);
        ot <= 1'b1;
        cyc(8);
        check("hot", {rxd_out, bus_drive_low}, 32'h2);
        ot <= 1'b0;
        cyc(8);
        check("hot cleared", {31'h0, rxd_out}, 32'h0);
        node.set_remote(1'b0);
        uv <= 1'b1;
        node.set_txd(1'b0);
        cyc(10);
        check("undervoltage", {31'h0, bus_drive_low}, 32'h0);
        uv <= 1'b0;
        node.set_txd(1'b1);
        xfer(LNT_IRQ_OFS, 1'b1, 32'h0000000F);
        xfer(LNT_MASK_OFS, 1'b1, 32'h00000001);
        node.set_txd(1'b0);
        cyc(TXDOM + 10);
        check("timeout", {30'h0, irq, bus_drive_low}, 32'h2);
        xfer(LNT_STAT_OFS, 1'b0, 32'h0);
        check("lock flag", {31'h0, rd[LNT_STAT_DOM_BIT]}, 32'h1);
        cyc(20);
        check("lock held", {31'h0, bus_drive_low}, 32'h0);
        node.set_txd(1'b1);
        cyc(6);
        node.set_txd(1'b0);
        cyc(8);
        check("lock released", {31'h0, bus_drive_low}, 32'h1);
        node.set_txd(1'b1);
        xfer(LNT_IRQ_OFS, 1'b1, 32'h0000000F);
        cyc(3);
        check("irq cleared", {31'h0, irq}, 32'h0);
        xfer(LNT_CTRL_OFS, 1'b1, ctrl(LNT_MODE_DIS, LNT_RATE_20K, 1'b0, 1'b0));
        node.set_txd(1'b0);
        cyc(4);
        xfer(LNT_CTRL_OFS, 1'b1, ctrl(LNT_MODE_TXRX, LNT_RATE_20K, 1'b0, 1'b0));
        node.set_txd(1'b1);
        xfer(LNT_STAT_OFS, 1'b0, 32'h0);
        check("txrx refused", {30'h0, rd[1:0]}, {30'h0, LNT_MODE_DIS});
        xfer(LNT_CTRL_OFS, 1'b1, ctrl(LNT_MODE_TXRX, LNT_RATE_20K, 1'b0, 1'b0));
        xfer(LNT_STAT_OFS, 1'b0, 32'h0);
        check("txrx taken", {30'h0, rd[1:0]}, {30'h0, LNT_MODE_TXRX});
        xfer(LNT_MASK_OFS, 1'b1, 32'h00000002);
        xfer(LNT_CTRL_OFS, 1'b1, ctrl(LNT_MODE_SLEEP, LNT_RATE_20K, 1'b0, 1'b1));
        node.set_txd(1'b0);
        cyc(8);
        check("sleep", {weak_pu, normal_pu, bus_drive_low}, 32'h4);
        node.set_txd(1'b1);
        pulse(WAKE + 10);
        check("wake disabled", n_wake, 32'h0);
        xfer(LNT_CTRL_OFS, 1'b1, ctrl(LNT_MODE_SLEEP, LNT_RATE_20K, 1'b1, 1'b1));
        pulse(WAKE / 2);
        check("short pulse", n_wake, 32'h0);
        pulse(WAKE + 10);
        check("wake", {n_wake[29:0], irq, reg_restart}, 32'h6);
        xfer(LNT_CTRL_OFS, 1'b1, ctrl(LNT_MODE_SLEEP, LNT_RATE_20K, 1'b1, 1'b0));
        pulse(WAKE + 10);
        check("restart", n_restart, 32'h1);
        xfer(LNT_CTRL_OFS, 1'b1, ctrl(LNT_MODE_TXRX, LNT_RATE_20K, 1'b0, 1'b0));
        cyc(4);
        check("awake pull-up", {weak_pu, normal_pu}, 32'h1);
        end_sim();
    end
endmodule
